// ===== logic/led_ramp_pkg.sv
// constants and types of the led command and ramp sequencer
//
// Operation
// - ramp time is step time times steps
// - step level one at a time to target
// - level never leaves zero to maximum range
// - bad command sequences leave defined state
// - peak command applies level directly, no ramp
// - transition starts at acknowledge of command byte
// - every register loaded by its own byte
// - function 000 shuts down, low bits ignored
// - function 001 stores shared peak level
// - functions 010..100 store channel duty values
// - function 101 stores rise target, selects up
// - function 110 stores fall target, selects down
// - function 111 stores step time, starts ramp
// - step time is field times 8 ms
// - step count is distance from present level
// - a ramp spans at most 31 steps
// - write address byte is 0x72, read ignored
// - level zero is off, 30 and 31 equal
// - duty 00 fully off, 1F fully on
`default_nettype none

package led_ramp_pkg;

    localparam int         LEVEL_W          = 5;
    localparam int         CHANNELS         = 3;
    localparam logic [7:0] WRITE_ADDR       = 8'h72;
    localparam logic [3:0] BYTE_BITS        = 4'h8;

    localparam logic [2:0] FN_SHUTDOWN      = 3'h0;
    localparam logic [2:0] FN_PEAK          = 3'h1;
    localparam logic [2:0] FN_DUTY_ONE      = 3'h2;
    localparam logic [2:0] FN_RISE          = 3'h5;
    localparam logic [2:0] FN_FALL          = 3'h6;
    localparam logic [2:0] FN_RUN           = 3'h7;

    localparam logic [4:0] LEVEL_ZERO       = 5'h00;
    localparam logic [4:0] LEVEL_MAX        = 5'h1F;
    localparam logic [4:0] LEVEL_SAT        = 5'h1E;
    localparam logic [4:0] DUTY_OFF         = 5'h00;
    localparam logic [4:0] DUTY_ON          = 5'h1F;
    localparam logic [4:0] FIELD_RESET      = 5'h00;

    localparam int         CLK_HZ           = 25000000;
    localparam int         STEP_UNIT_MS     = 8;
    localparam int         STEP_UNIT_CYCLES = STEP_UNIT_MS * (CLK_HZ / 1000);

    typedef struct packed {
        logic [2:0] func;
        logic [4:0] value;
    } command_t;

    typedef enum logic [2:0] {
        LINK_IDLE,
        LINK_ADDR,
        LINK_ADDR_ACK,
        LINK_DATA,
        LINK_DATA_ACK,
        LINK_SKIP
    } link_state_t;

endpackage

`default_nettype wire

// ===== logic/pin_sync2.sv
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk)
    begin
        meta <= din;
        dout <= meta;
    end

endmodule

`default_nettype wire

// ===== logic/link_byte_capture.sv
// serial data shifter running on the link clock
`timescale 1ns/1ps
`default_nettype none

module link_byte_capture (
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic      [7:0] rx_shift
);

    // msb first; the word stands still while the link clock is low
    always_ff @(posedge scl)
    begin
        rx_shift <= {rx_shift[6:0], sda_in};
    end

endmodule

`default_nettype wire

// ===== logic/led_command_ramp_sequencer.sv
// command receiver, registers and ramp sequencer of the led driver
`timescale 1ns/1ps
`default_nettype none

module led_command_ramp_sequencer #(
    parameter int STEP_UNIT_CYCLES = led_ramp_pkg::STEP_UNIT_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic [4:0]      channel_peak_current,
    output logic [2:0][4:0] channel_duty,
    output logic [2:0]      channel_full_off,
    output logic [2:0]      channel_full_on,
    output logic [4:0]      ramp_end_level,
    output logic [4:0]      ramp_steps_left,
    output logic            ramp_busy,
    output logic            shutdown_active
);

    localparam int UNIT_W = $clog2(STEP_UNIT_CYCLES + 1);

    generate
        if (STEP_UNIT_CYCLES < 1)
        begin : g_bad_unit
            $error("step unit must be at least one cycle");
        end
    endgenerate

    // ==========================================================
    // pin synchronisers and link-clock capture
    logic [1:0] pins_s;
    logic [7:0] rx_shift;
    logic       scl_q;
    logic       sda_q;

    pin_sync2 #(
        .WIDTH (2)
    ) u_sync (
        .clk  (sys_clk),
        .din  ({scl, sda_in}),
        .dout (pins_s)
    );

    link_byte_capture u_capture (
        .scl      (scl),
        .sda_in   (sda_in),
        .rx_shift (rx_shift)
    );

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= pins_s[1];
            sda_q <= pins_s[0];
        end
    end

    wire logic scl_s     = pins_s[1];
    wire logic sda_s     = pins_s[0];
    wire logic scl_rise  = scl_s & ~scl_q;
    wire logic scl_fall  = ~scl_s & scl_q;
    wire logic bus_start = scl_s & scl_q & sda_q & ~sda_s;
    wire logic bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

    // ==========================================================
    // byte framing and acknowledge
    led_ramp_pkg::link_state_t link_state;
    led_ramp_pkg::link_state_t next_link_state;
    logic [3:0]                bit_cnt;
    logic [3:0]                next_bit_cnt;
    logic [7:0]                rx_byte;

    wire logic byte_done = (bit_cnt == led_ramp_pkg::BYTE_BITS);
    wire logic in_byte   = (link_state == led_ramp_pkg::LINK_ADDR)
                         | (link_state == led_ramp_pkg::LINK_DATA);
    wire logic in_ack    = (link_state == led_ramp_pkg::LINK_ADDR_ACK)
                         | (link_state == led_ramp_pkg::LINK_DATA_ACK);
    wire logic addr_hit  = (rx_byte == led_ramp_pkg::WRITE_ADDR);
    wire logic last_bit  = (bit_cnt == 4'h7);

    always_comb
    begin
        next_link_state = link_state;
        next_bit_cnt    = bit_cnt;
        if (bus_stop)
        begin
            next_link_state = led_ramp_pkg::LINK_IDLE;
            next_bit_cnt    = 4'h0;
        end
        else if (bus_start)
        begin
            next_link_state = led_ramp_pkg::LINK_ADDR;
            next_bit_cnt    = 4'h0;
        end
        else
        begin
            case (link_state)
                led_ramp_pkg::LINK_ADDR,
                led_ramp_pkg::LINK_DATA:
                begin
                    if (scl_rise && !byte_done)
                        next_bit_cnt = bit_cnt + 4'h1;
                    else if (scl_fall && byte_done)
                    begin
                        next_bit_cnt = 4'h0;
                        if (link_state == led_ramp_pkg::LINK_DATA)
                            next_link_state = led_ramp_pkg::LINK_DATA_ACK;
                        else if (addr_hit)
                            next_link_state = led_ramp_pkg::LINK_ADDR_ACK;
                        else
                            next_link_state = led_ramp_pkg::LINK_SKIP;
                    end
                end
                led_ramp_pkg::LINK_ADDR_ACK,
                led_ramp_pkg::LINK_DATA_ACK:
                begin
                    // ninth clock: release after its falling edge
                    if (scl_rise)
                        next_bit_cnt = 4'h1;
                    else if (scl_fall && bit_cnt != 4'h0)
                    begin
                        next_bit_cnt    = 4'h0;
                        next_link_state = led_ramp_pkg::LINK_DATA;
                    end
                end
                led_ramp_pkg::LINK_IDLE,
                led_ramp_pkg::LINK_SKIP:
                    next_bit_cnt = 4'h0;
                default:
                begin
                    next_link_state = led_ramp_pkg::LINK_IDLE;
                    next_bit_cnt    = 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            link_state <= led_ramp_pkg::LINK_IDLE;
            bit_cnt    <= 4'h0;
            rx_byte    <= 8'h00;
        end
        else
        begin
            link_state <= next_link_state;
            bit_cnt    <= next_bit_cnt;
            // shifter has been stable two cycles when the edge is seen
            if (in_byte && scl_rise && last_bit)
                rx_byte <= rx_shift;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = in_ack;

    // ==========================================================
    // command decode, applied as the data byte is acknowledged
    wire logic cmd_fire = (link_state == led_ramp_pkg::LINK_DATA)
                        & scl_fall & byte_done;
    led_ramp_pkg::command_t cmd;
    assign cmd = rx_byte;

    wire logic is_shut = cmd_fire && cmd.func == led_ramp_pkg::FN_SHUTDOWN;
    wire logic is_peak = cmd_fire && cmd.func == led_ramp_pkg::FN_PEAK;
    wire logic is_rise = cmd_fire && cmd.func == led_ramp_pkg::FN_RISE;
    wire logic is_fall = cmd_fire && cmd.func == led_ramp_pkg::FN_FALL;
    wire logic is_run  = cmd_fire && cmd.func == led_ramp_pkg::FN_RUN;

    // ==========================================================
    // ramp state
    logic [4:0]        peak_level;
    logic [4:0]        next_peak_level;
    logic              next_ramp_busy;
    logic [4:0]        rise_target;
    logic [4:0]        fall_target;
    logic [4:0]        step_time;
    logic              dir_up;
    logic              shutdown;
    logic [UNIT_W-1:0] unit_cnt;
    logic [4:0]        tick_cnt;
    logic [2:0][4:0]   duty;

    // direction comes from whichever target was written last
    wire logic [4:0] run_target = dir_up ? rise_target : fall_target;
    wire logic unit_tick = (unit_cnt == UNIT_W'(STEP_UNIT_CYCLES - 1));
    wire logic step_fire = ramp_busy & unit_tick
                         & (tick_cnt == step_time - 5'h01);
    wire logic go_up     = (peak_level < ramp_end_level);
    wire logic [4:0] level_up = (peak_level < led_ramp_pkg::LEVEL_MAX)
                              ? peak_level + 5'h01 : peak_level;
    wire logic [4:0] level_dn = (peak_level > led_ramp_pkg::LEVEL_ZERO)
                              ? peak_level - 5'h01 : peak_level;
    wire logic [4:0] stepped  = go_up ? level_up : level_dn;
    wire logic [4:0] distance = go_up ? ramp_end_level - peak_level
                              : peak_level - ramp_end_level;

    always_comb
    begin
        next_peak_level = peak_level;
        next_ramp_busy  = ramp_busy;
        if (is_shut)
        begin
            next_peak_level = led_ramp_pkg::LEVEL_ZERO;
            next_ramp_busy  = 1'b0;
        end
        else if (is_peak)
        begin
            next_peak_level = cmd.value;
            next_ramp_busy  = 1'b0;
        end
        else if (is_run)
        begin
            // zero step time jumps at once; already there runs no step
            if (cmd.value == 5'h00)
                next_peak_level = run_target;
            next_ramp_busy = (cmd.value != 5'h00)
                           && (peak_level != run_target);
        end
        else if (step_fire)
        begin
            next_peak_level = stepped;
            next_ramp_busy  = (stepped != ramp_end_level);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            peak_level     <= led_ramp_pkg::FIELD_RESET;
            ramp_busy      <= 1'b0;
            ramp_end_level <= led_ramp_pkg::FIELD_RESET;
            step_time      <= led_ramp_pkg::FIELD_RESET;
            rise_target    <= led_ramp_pkg::FIELD_RESET;
            fall_target    <= led_ramp_pkg::FIELD_RESET;
            dir_up         <= 1'b1;
            shutdown       <= 1'b1;
        end
        else
        begin
            peak_level <= next_peak_level;
            ramp_busy  <= next_ramp_busy;
            if (cmd_fire)
                shutdown <= is_shut;
            if (is_rise)
            begin
                rise_target <= cmd.value;
                dir_up      <= 1'b1;
            end
            if (is_fall)
            begin
                fall_target <= cmd.value;
                dir_up      <= 1'b0;
            end
            if (is_run)
            begin
                step_time      <= cmd.value;
                ramp_end_level <= run_target;
            end
        end
    end

    // step interval: step_time units of one step unit each
    always_ff @(posedge sys_clk)
    begin
        if (rst || is_run || !ramp_busy)
        begin
            unit_cnt <= '0;
            tick_cnt <= 5'h00;
        end
        else if (unit_tick)
        begin
            unit_cnt <= '0;
            tick_cnt <= step_fire ? 5'h00 : tick_cnt + 5'h01;
        end
        else
            unit_cnt <= unit_cnt + UNIT_W'(1);
    end

    // ==========================================================
    // duty registers and channel outputs
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            channel_peak_current <= led_ramp_pkg::LEVEL_ZERO;
            ramp_steps_left      <= 5'h00;
            shutdown_active      <= 1'b1;
        end
        else
        begin
            shutdown_active <= shutdown;
            ramp_steps_left <= ramp_busy ? distance : 5'h00;
            if (shutdown)
                channel_peak_current <= led_ramp_pkg::LEVEL_ZERO;
            else if (peak_level == led_ramp_pkg::LEVEL_MAX)
                channel_peak_current <= led_ramp_pkg::LEVEL_SAT;
            else
                channel_peak_current <= peak_level;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < led_ramp_pkg::CHANNELS; ch++)
        begin : g_chan
            wire logic duty_we = cmd_fire
                && (cmd.func == 3'(led_ramp_pkg::FN_DUTY_ONE + ch));
            wire logic off_now = shutdown
                || duty[ch] == led_ramp_pkg::DUTY_OFF
                || peak_level == led_ramp_pkg::LEVEL_ZERO;

            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    duty[ch]             <= led_ramp_pkg::FIELD_RESET;
                    channel_duty[ch]     <= led_ramp_pkg::DUTY_OFF;
                    channel_full_off[ch] <= 1'b1;
                    channel_full_on[ch]  <= 1'b0;
                end
                else
                begin
                    if (duty_we)
                        duty[ch] <= cmd.value;
                    channel_duty[ch]     <= shutdown
                                          ? led_ramp_pkg::DUTY_OFF
                                          : duty[ch];
                    channel_full_off[ch] <= off_now;
                    channel_full_on[ch]  <= !off_now
                        && duty[ch] == led_ramp_pkg::DUTY_ON;
                end
            end
        end
    endgenerate

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    int gap_cnt;
    always_ff @(posedge sys_clk)
    begin
        if (rst || is_run || step_fire)
            gap_cnt <= 0;
        else
            gap_cnt <= gap_cnt + 1;
    end

    chk_step_spacing: assert property (
        step_fire |-> gap_cnt == int'(step_time) * STEP_UNIT_CYCLES - 1)
        else $error("ramp step taken at the wrong time");

    chk_step_by_one: assert property (
        $past(ramp_busy) && !$past(cmd_fire) && $changed(peak_level)
        |-> (peak_level == $past(peak_level) + 5'h01)
         || (peak_level == $past(peak_level) - 5'h01))
        else $error("ramp moved by more than one step");

    chk_stops_at_target: assert property (
        ramp_busy && peak_level == ramp_end_level && !cmd_fire
        |=> !ramp_busy)
        else $error("ramp kept running at its target");

    chk_shutdown_zero: assert property (
        is_shut |=> ##1 channel_peak_current == 5'h00
                     && channel_full_off == 3'h7 && !ramp_busy)
        else $error("shutdown left a channel driven");

    chk_direct_peak: assert property (
        is_peak |=> peak_level == $past(cmd.value) && !ramp_busy)
        else $error("peak level not applied directly");

    chk_duty_store: assert property (
        cmd_fire && cmd.func == led_ramp_pkg::FN_DUTY_ONE
        |=> duty[0] == $past(cmd.value))
        else $error("channel one duty not stored");

    chk_zero_steps: assert property (
        is_run && peak_level == run_target |=> !ramp_busy)
        else $error("ramp started with no steps to run");

    chk_run_target: assert property (
        is_run |=> ramp_end_level == $past(run_target)
                && step_time == $past(cmd.value))
        else $error("run command latched wrong target or time");

    chk_level_sat: assert property (
        channel_peak_current != led_ramp_pkg::LEVEL_MAX)
        else $error("level 31 not folded onto 30");

    chk_ack_on_data: assert property (
        cmd_fire |=> sda_oe [*2])
        else $error("command byte not acknowledged");

    cov_run_ramp: cover property (is_run ##1 ramp_busy);
    cov_ramp_done: cover property ($fell(ramp_busy) && !$past(cmd_fire));
    cov_shutdown: cover property (is_shut);
    cov_addr_miss: cover property (link_state == led_ramp_pkg::LINK_SKIP);

endmodule

`default_nettype wire

// ===== tb/link_master_model.sv
// controller model that writes command frames over the two-wire link
`timescale 1ns/1ps
`default_nettype none

module link_master_model (
    input  wire logic link_clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_low
);
    // link idles with clock high and data released
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge link_clk);
    endtask

    // data changes only in mid low phase, sampled in mid high phase
    task automatic bit_out(input logic b, output logic seen);
        scl = 1'b0;
        ticks(10);
        sda_low = ~b;
        ticks(10);
        scl = 1'b1;
        ticks(10);
        seen = sda_wire;
        ticks(10);
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_out(b[i], s);
        bit_out(1'b1, s);
        ack = ~s;
    endtask

    task automatic write_frame(input logic [7:0] addr,
                               input logic [7:0] cmd,
                               output logic ack_a,
                               output logic ack_d);
        sda_low = 1'b1;
        ticks(20);
        send(addr, ack_a);
        send(cmd, ack_d);
        scl = 1'b0;
        ticks(10);
        sda_low = 1'b1;
        ticks(10);
        scl = 1'b1;
        ticks(20);
        sda_low = 1'b0;
        ticks(40);
    endtask
endmodule

`default_nettype wire

// ===== tb/led_command_ramp_sequencer_tb.sv
// self-checking bench for the led command and ramp sequencer
`timescale 1ns/1ps
`default_nettype none

module led_command_ramp_sequencer_tb;
    localparam int SU    = 4;
    localparam int LIMIT = 30000;

    logic            sys_clk;
    logic            rst;
    logic            link_clk;
    logic            scl;
    logic            sda_low;
    logic            sda_wire;
    logic            sda_out;
    logic            sda_oe;
    logic [4:0]      peak;
    logic [2:0][4:0] duty;
    logic [2:0]      full_off;
    logic [2:0]      full_on;
    logic [4:0]      end_level;
    logic [4:0]      steps_left;
    logic            busy;
    logic            shut;
    logic [4:0]      prev;
    logic            busy_seen;
    logic            ack_a;
    logic            ack_d;
    logic [4:0]      vals [3];
    int              n_fail;
    int              n_tests;
    int              cyc;
    int              t_chg [$];
    logic [4:0]      v_chg [$];

    // pull-up on the data wire
    assign sda_wire = ~(sda_low | (sda_oe & ~sda_out));

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial
    begin
        link_clk = 1'b0;
        #3.7;
        forever #6 link_clk = ~link_clk;
    end

    led_command_ramp_sequencer #(
        .STEP_UNIT_CYCLES(SU)
    ) dut (
        .sys_clk             (sys_clk),
        .rst                 (rst),
        .scl                 (scl),
        .sda_in              (sda_wire),
        .sda_out             (sda_out),
        .sda_oe              (sda_oe),
        .channel_peak_current(peak),
        .channel_duty        (duty),
        .channel_full_off    (full_off),
        .channel_full_on     (full_on),
        .ramp_end_level      (end_level),
        .ramp_steps_left     (steps_left),
        .ramp_busy           (busy),
        .shutdown_active     (shut)
    );

    link_master_model u_ctl (
        .link_clk(link_clk),
        .sda_wire(sda_wire),
        .scl     (scl),
        .sda_low (sda_low)
    );

    // ==========================================================
    // monitor: time stamps of level changes, timeout
    always @(negedge sys_clk)
    begin
        cyc++;
        if (busy === 1'b1)
            busy_seen = 1'b1;
        if (!rst && peak !== prev)
        begin
            t_chg.push_back(cyc);
            v_chg.push_back(peak);
        end
        prev = peak;
        if (cyc >= LIMIT)
        begin
            n_fail++;
            conclude();
        end
    end

    // ==========================================================
    // tasks
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cmd(input logic [7:0] b);
        u_ctl.write_frame(8'h72, b, ack_a, ack_d);
        check("address ack", ack_a, 1'b1);
        check("command ack", ack_d, 1'b1);
        repeat (4) @(negedge sys_clk);
    endtask

    // target then run; every visible step checked for value, each after the first for spacing
    task automatic ramp(input logic [7:0] tgt_cmd, input logic [4:0] unit,
                        input logic [4:0] from);
        logic [4:0] lvl;
        logic [4:0] shown;
        logic [4:0] last;
        int         n;
        int         w;
        lvl = from;
        last = from;
        n = 0;
        w = 0;
        cmd(tgt_cmd);
        t_chg.delete();
        v_chg.delete();
        busy_seen = 1'b0;
        cmd({3'h7, unit});
        check("end level", end_level, tgt_cmd[4:0]);
        while (busy !== 1'b0 && w < 2000)
        begin
            @(negedge sys_clk);
            w++;
        end
        repeat (4) @(negedge sys_clk);
        while (lvl != tgt_cmd[4:0])
        begin
            if (unit == 5'h00)
                lvl = tgt_cmd[4:0];
            else if (lvl < tgt_cmd[4:0])
                lvl = lvl + 5'h01;
            else
                lvl = lvl - 5'h01;
            shown = (lvl == 5'h1F) ? 5'h1E : lvl;
            if (shown != last)
            begin
                check("step level", v_chg[n], shown);
                if (n > 0)
                    check("step gap", t_chg[n]-t_chg[n-1], unit*SU);
                n++;
            end
            last = shown;
        end
        check("step count", t_chg.size(), n);
        check("busy seen", busy_seen, |unit && from != tgt_cmd[4:0]);
        check("final level", peak, last);
        check("steps left", steps_left, 5'h00);
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        rst = 1'b1;
        n_fail = 0;
        n_tests = 0;
        cyc = 0;
        prev = 5'h00;
        busy_seen = 1'b0;
        vals = '{5'h00, 5'h1F, 5'h0A};
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        check("reset shutdown", shut, 1'b1);
        check("reset off", full_off, 3'h7);
        u_ctl.write_frame(8'h73, 8'h3F, ack_a, ack_d);
        check("read address ack", ack_a, 1'b0);
        check("ignored level", peak, 5'h00);
        cmd(8'h25);
        check("direct level", peak, 5'h05);
        check("no ramp", busy, 1'b0);
        check("shutdown left", shut, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            cmd({3'h2 + i[2:0], vals[i]});
            check("duty", duty[i], vals[i]);
        end
        check("full off", full_off, 3'h1);
        check("full on", full_on, 3'h2);
        ramp(8'hB0, 5'h03, 5'h05);
        ramp(8'hC1, 5'h04, 5'h10);
        ramp(8'hC1, 5'h02, 5'h01);
        ramp(8'hB4, 5'h00, 5'h01);
        ramp(8'hBF, 5'h01, 5'h14);
        cmd(8'h23);
        check("direct after ramp", peak, 5'h03);
        cmd(8'hBA);
        cmd(8'hE5);
        check("ramp running", busy, 1'b1);
        check("steps remaining", steps_left, 5'h1A - peak);
        cmd(8'h28);
        check("abort busy", busy, 1'b0);
        check("abort level", peak, 5'h08);
        cmd(8'h1F);
        check("shutdown", shut, 1'b1);
        check("shutdown level", peak, 5'h00);
        check("shutdown duty", duty, 15'h0000);
        check("shutdown off", full_off, 3'h7);
        cmd(8'h41);
        check("wake", shut, 1'b0);
        check("wake duty", duty[0], 5'h01);
        conclude();
    end
endmodule

`default_nettype wire
